/* File: design/xalu_top.sv */
// Extended ALU datapath with an APB register front end.
// Assumes an APB master on clk_sys; one transfer at a time.
`timescale 1ns/1ps
`include "xalu_cfg.svh"

module xalu_top
    import xalu_pkg::*;
(
    input  wire logic    clk_sys,  // System clock, 100 MHz
    input  wire logic    rst,      // Async reset, active high
    input  xalu_apb_req_t apbReq,  // APB request group
    output xalu_apb_rsp_t apbRsp,  // APB answer group
    output logic [15:0]  srOut     // Status register copy
);

    xalu_state_t st_ff;
    xalu_state_t nxt_st;
    xalu_exe_t   exe;
    xalu_op_t    opDec;
    xalu_size_t  szDec;
    logic        opOk;
    logic        setupCyc;
    logic        accessEdge;
    logic        wrEdge;
    logic        hit;
    logic [31:0] rdMux;

    // Execution of one operation on the held operands
    function automatic xalu_exe_t run(
        input xalu_op_t    op,
        input xalu_size_t  szIn,
        input logic        mem,
        input logic [31:0] s,
        input logic [31:0] d,
        input logic        cin
    );
        xalu_exe_t   e;
        xalu_size_t  sz;
        logic [31:0] mask;
        logic [4:0]  msb;
        logic [32:0] add;
        logic [31:0] r;
        logic [15:0] sw;
        begin
            e   = '0;
            add = '0;
            r   = '0;
            sz  = szIn;
            // Swap and extend have no byte form; byte is taken as word
            if ((op == OP_SWPB || op == OP_SXT) && sz == SZ_B)
            begin
                sz = SZ_W;
            end
            case (sz)
                SZ_B:
                begin
                    mask = `XALU_MASK_B;
                    msb  = `XALU_MSB_B;
                end
                SZ_W:
                begin
                    mask = `XALU_MASK_W;
                    msb  = `XALU_MSB_W;
                end
                default:
                begin
                    mask = `XALU_MASK_A;
                    msb  = `XALU_MSB_A;
                end
            endcase
            sw = {d[7:0], d[15:8]};
            case (op)
                OP_SUBC:
                begin
                    // dst + not src + carry
                    add = {1'b0, d & mask} + {1'b0, ~s & mask} + {32'h0, cin};
                    r = add[31:0] & mask;
                    e.c = add[msb + 5'h01];
                    e.v = (s[msb] & ~d[msb] & r[msb]) | (~s[msb] & d[msb] & ~r[msb]);
                    e.wr  = 1'b1;
                    e.upd = 1'b1;
                end
                OP_XOR:
                begin
                    r = (s ^ d) & mask;
                    e.c = |r;
                    e.v = s[msb] & d[msb];
                    e.wr  = 1'b1;
                    e.upd = 1'b1;
                end
                OP_TST:
                begin
                    // dst + all ones + 1, no write
                    add = {1'b0, d & mask} + {1'b0, mask} + 33'h000000001;
                    r = add[31:0] & mask;
                    // carry from the sum is always one
                    e.c = add[msb + 5'h01];
                    e.v = 1'b0;
                    e.wr  = 1'b0;
                    e.upd = 1'b1;
                end
                OP_SXT:
                begin
                    if (mem && sz == SZ_W)
                    begin
                        r = {d[31:16], {8{d[7]}}, d[7:0]};
                    end
                    else
                    begin
                        r = {12'h000, {12{d[7]}}, d[7:0]};
                    end
                    // carry is not zero, V cleared
                    e.c   = |(r & mask);
                    e.v   = 1'b0;
                    e.wr  = 1'b1;
                    e.upd = 1'b1;
                end
                default:
                begin
                    if (sz == SZ_A)
                    begin
                        r = {12'h000, d[19:16], sw};
                    end
                    else if (mem)
                    begin
                        r = {d[31:16], sw};
                    end
                    else
                    begin
                        r = {16'h0000, sw};
                    end
                    e.upd = 1'b0;
                    e.wr  = 1'b1;
                end
            endcase
            // Memory byte and word results keep the rest of dst; address-word clears 31:20
            if (mem && (op == OP_SUBC || op == OP_XOR))
            begin
                case (sz)
                    SZ_B:    r = {d[31:8], r[7:0]};
                    SZ_W:    r = {d[31:16], r[15:0]};
                    default: r = {12'h000, r[19:0]};
                endcase
            end
            // register word results already have 19:16 clear, except sign extend, which fills 19:8
            e.n = r[msb];
            e.z = ~|(r & mask);
            e.res = r;
            run = e;
        end
    endfunction

    // Control field decode
    always_comb
    begin
        opOk  = 1'b1;
        opDec = OP_SUBC;
        szDec = SZ_A;
        case (apbReq.pwdata[`XALU_CT_OP])
            `XALU_OPC_SUBC: opDec = OP_SUBC;
            `XALU_OPC_SWPB: opDec = OP_SWPB;
            `XALU_OPC_SXT:  opDec = OP_SXT;
            `XALU_OPC_TST:  opDec = OP_TST;
            `XALU_OPC_XOR:  opDec = OP_XOR;
            default:        opOk  = 1'b0;
        endcase
        case (apbReq.pwdata[`XALU_CT_SZ])
            `XALU_SZC_B: szDec = SZ_B;
            `XALU_SZC_W: szDec = SZ_W;
            default:     szDec = SZ_A;
        endcase
    end

    // Operands come from the registers as they stand before the write
    assign exe = run(opDec, szDec, apbReq.pwdata[`XALU_CT_MEM], st_ff.src, st_ff.dst,
                     st_ff.sr[`XALU_SR_C]);

    // Bus phases: answer is ready in the first access cycle
    assign setupCyc   = apbReq.psel & ~apbReq.penable;
    assign accessEdge = apbReq.psel & apbReq.penable & st_ff.rsp.pready;
    assign wrEdge     = accessEdge & apbReq.pwrite;

    // Read mux and address decode
    always_comb
    begin
        hit   = 1'b1;
        rdMux = 32'h00000000;
        case (apbReq.paddr)
            `XALU_OFF_CTRL: rdMux = 32'h00000000;
            `XALU_OFF_SRC:  rdMux = st_ff.src;
            `XALU_OFF_DST:  rdMux = st_ff.dst;
            `XALU_OFF_SR:   rdMux = {16'h0000, st_ff.sr};
            `XALU_OFF_RES:  rdMux = st_ff.res;
            `XALU_OFF_PTR:  rdMux = {12'h000, st_ff.ptr};
            `XALU_OFF_STAT: rdMux = {30'h00000000, st_ff.badOp, st_ff.wrote};
            default:        hit   = 1'b0;
        endcase
    end

    // Next state
    always_comb
    begin
        nxt_st = st_ff;
        // Answer phase; pready drops after one access cycle
        nxt_st.rsp.pready = setupCyc;
        if (setupCyc)
        begin
            nxt_st.rsp.prdata  = apbReq.pwrite ? 32'h00000000 : rdMux;
            nxt_st.rsp.pslverr = ~hit;
        end
        else if (accessEdge)
        begin
            nxt_st.rsp.pslverr = 1'b0;
        end
        if (wrEdge)
        begin
            case (apbReq.paddr)
                `XALU_OFF_SRC: nxt_st.src = apbReq.pwdata;
                `XALU_OFF_DST: nxt_st.dst = apbReq.pwdata;
                `XALU_OFF_SR:  nxt_st.sr  = apbReq.pwdata[15:0];
                `XALU_OFF_PTR: nxt_st.ptr = apbReq.pwdata[19:0];
                `XALU_OFF_CTRL:
                begin
                    nxt_st.badOp = ~opOk;
                    nxt_st.wrote = 1'b0;
                    // Unknown codes do nothing beyond flagging
                    if (opOk)
                    begin
                        nxt_st.res   = exe.res;
                        nxt_st.wrote = exe.wr;
                        if (exe.wr)
                        begin
                            nxt_st.dst = exe.res;
                        end
                        // only C, Z, N, V are written
                        if (exe.upd)
                        begin
                            nxt_st.sr[`XALU_SR_C] = exe.c;
                            nxt_st.sr[`XALU_SR_Z] = exe.z;
                            nxt_st.sr[`XALU_SR_N] = exe.n;
                            nxt_st.sr[`XALU_SR_V] = exe.v;
                        end
                        if (apbReq.pwdata[`XALU_CT_INC] &&
                            (opDec == OP_SUBC || opDec == OP_XOR))
                        begin
                            case (szDec)
                                SZ_B:    nxt_st.ptr = st_ff.ptr + `XALU_INC_B;
                                SZ_W:    nxt_st.ptr = st_ff.ptr + `XALU_INC_W;
                                default: nxt_st.ptr = st_ff.ptr + `XALU_INC_A;
                            endcase
                        end
                    end
                end
                default:
                begin
                    nxt_st.wrote = st_ff.wrote;
                end
            endcase
        end
    end

    // State register; the source operand is never written by an operation
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_ff    <= '0;
            st_ff.sr <= `XALU_SR_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign apbRsp = st_ff.rsp;
    assign srOut  = st_ff.sr;

endmodule

/* File: design/xalu_cfg.svh */
// Offsets, field positions and constants of the extended ALU unit.
// Assumes an APB master on clk_sys and byte addresses on paddr.
// Contract
// - Subtract-with-carry writes dst plus not-src plus carry
// - Subtract and XOR: N from MSB, Z on zero
// - Subtract carry is carry out of size MSB
// - Subtract overflow on sign-inconsistent result
// - Register address-word swap keeps bits 19:16
// - Register word swap clears bits 19:16
// - Memory swap: address-word clears 31:20, word swaps
// - Byte swap never touches arithmetic flags
// - Register sign extend fills 19:8 from bit 7
// - Memory address-word extend fills 19:8, clears 31:20
// - Memory word extend fills only 15:8
// - Sign extend: carry is not zero, overflow cleared
// - Test adds all-ones plus one, no writeback
// - Test: N, Z from destination, C set, V cleared
// - XOR writes source XOR destination, source untouched
// - XOR carry is inverse of zero
// - XOR overflow only when both operands negative
// - Mode bits of status never altered
// - Word register clears 19:16, post-increment adds two; register word sign extend fills 19:8 from bit 7 instead
// - N from bit 19, 15 or 7
`ifndef XALU_CFG_SVH
`define XALU_CFG_SVH
// Register byte offsets
`define XALU_OFF_CTRL 8'h00
`define XALU_OFF_SRC  8'h04
`define XALU_OFF_DST  8'h08
`define XALU_OFF_SR   8'h0c
`define XALU_OFF_RES  8'h10
`define XALU_OFF_PTR  8'h14
`define XALU_OFF_STAT 8'h18
// Status register bits
`define XALU_SR_C 0
`define XALU_SR_Z 1
`define XALU_SR_N 2
`define XALU_SR_V 8
`define XALU_SR_RST 16'h0000
// Control register fields
`define XALU_CT_OP  2:0
`define XALU_CT_SZ  5:4
`define XALU_CT_MEM 8
`define XALU_CT_INC 9
// Operation and size codes
`define XALU_OPC_SUBC 3'h0
`define XALU_OPC_SWPB 3'h1
`define XALU_OPC_SXT  3'h2
`define XALU_OPC_TST  3'h3
`define XALU_OPC_XOR  3'h4
`define XALU_SZC_B 2'h0
`define XALU_SZC_W 2'h1
// Widths per size
`define XALU_MSB_B 5'h07
`define XALU_MSB_W 5'h0f
`define XALU_MSB_A 5'h13
`define XALU_MASK_B 32'h000000ff
`define XALU_MASK_W 32'h0000ffff
`define XALU_MASK_A 32'h000fffff
`define XALU_INC_B 20'h00001
`define XALU_INC_W 20'h00002
`define XALU_INC_A 20'h00004
`endif

/* File: design/xalu_pkg.sv */
// Types shared by the extended ALU unit.
// Assumes xalu_cfg.svh is on the include path.
package xalu_pkg;
    typedef enum logic [2:0] {OP_SUBC, OP_SWPB, OP_SXT, OP_TST, OP_XOR} xalu_op_t;
    typedef enum logic [1:0] {SZ_B, SZ_W, SZ_A} xalu_size_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } xalu_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } xalu_apb_rsp_t;
    typedef struct packed {
        logic [31:0] res;
        logic        c;
        logic        z;
        logic        n;
        logic        v;
        logic        wr;
        logic        upd;
    } xalu_exe_t;
    typedef struct packed {
        logic [31:0]   src;
        logic [31:0]   dst;
        logic [15:0]   sr;
        logic [31:0]   res;
        logic [19:0]   ptr;
        logic          wrote;
        logic          badOp;
        xalu_apb_rsp_t rsp;
    } xalu_state_t;
endpackage

/* File: testbench/xalu_chk_sva.sv */
// Concurrent checks on the extended ALU ports and its APB answers.
// Assumes binding to xalu_top; sees only that module's ports.
`timescale 1ns/1ps
module xalu_chk
    import xalu_pkg::*;
(
    input wire logic          clk_sys, // System clock
    input wire logic          rst,     // Async reset, active high
    input wire xalu_apb_req_t apbReq,  // APB request group
    input wire xalu_apb_rsp_t apbRsp,  // APB answer group
    input wire logic [15:0]   srOut    // Status register copy
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Completed control write; the op runs at this edge
    logic       ctlWr;
    logic [2:0] wrOp;
    assign ctlWr = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
                   && apbReq.paddr == 8'h00;
    assign wrOp  = apbReq.pwdata[2:0];

    ready_after_setup_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
        else $error("Ready missing in first access cycle");
    ready_one_cycle_a: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("Ready held past one cycle");
    error_zero_data_a: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 0)
        else $error("Error answer without ready or with data");
    unmapped_error_a: assert property (apbReq.psel && !apbReq.penable
        && (apbReq.paddr > 8'h18 || apbReq.paddr[1:0] != 2'h0) |=> apbRsp.pslverr)
        else $error("Unmapped address not refused");
    swap_keeps_flags_a: assert property (ctlWr && wrOp == 3'h1 |=> $stable(srOut))
        else $error("Byte swap changed status");
    mode_bits_kept_a: assert property (ctlWr |=> (srOut & 16'hfef8) == ($past(srOut) & 16'hfef8))
        else $error("Operation changed mode bits");
    test_flags_a: assert property (ctlWr && wrOp == 3'h3 |=> srOut[0] && !srOut[8])
        else $error("Test left carry clear or overflow set");
    sext_flags_a: assert property (ctlWr && wrOp == 3'h2 |=> srOut[0] == !srOut[1] && !srOut[8])
        else $error("Sign extend flags wrong");
    xor_carry_a: assert property (ctlWr && wrOp == 3'h4 |=> srOut[0] == !srOut[1])
        else $error("XOR carry not inverse of zero");
endmodule

bind xalu_top xalu_chk xalu_chk_inst (
    .clk_sys(clk_sys),
    .rst    (rst),
    .apbReq (apbReq),
    .apbRsp (apbRsp),
    .srOut  (srOut)
);

/* File: testbench/xalu_top_tb.sv */
// Self-checking bench for the extended ALU over its APB registers.
// Assumes xalu_pkg and xalu_cfg.svh compiled ahead of this file.
`timescale 1ns/1ps
module xalu_top_tb
    import xalu_pkg::*;
;
    typedef struct packed {
        logic [9:0]  ctl;
        logic        cin;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] exp;
        logic [3:0]  f;   // V N Z C
    } xalu_row_t;

    logic          clk_sys;
    logic          rst;
    xalu_apb_req_t req;
    xalu_apb_rsp_t rsp;
    logic [15:0]   srOut;
    logic [31:0]   q;
    logic          e;
    int            errors;
    int            tests_run;
    xalu_row_t     r;
    // Op, size and space cases; hand-worked expectations
    xalu_row_t rows [15] = '{
        '{10'h020, 1'b1, 32'h1, 32'h5, 32'h4, 4'h1},
        '{10'h010, 1'b0, 32'h1, 32'ha8000, 32'h07ffe, 4'h9},
        '{10'h000, 1'b1, 32'h5, 32'h12305, 32'h0, 4'h3},
        '{10'h021, 1'b1, 32'h0, 32'h23456, 32'h25634, 4'h1},
        '{10'h011, 1'b0, 32'h0, 32'h23456, 32'h05634, 4'h0},
        '{10'h121, 1'b0, 32'h0, 32'hfff23456, 32'h00025634, 4'h0},
        '{10'h111, 1'b1, 32'h0, 32'habcd1234, 32'habcd3412, 4'h1},
        '{10'h012, 1'b0, 32'h0, 32'h00080, 32'hfff80, 4'h5},
        '{10'h122, 1'b0, 32'h0, 32'hfff0007f, 32'h0000007f, 4'h1},
        '{10'h112, 1'b0, 32'h0, 32'h12340080, 32'h1234ff80, 4'h5},
        '{10'h003, 1'b0, 32'h0, 32'h0, 32'h0, 4'h3},
        '{10'h013, 1'b0, 32'h0, 32'h08000, 32'h08000, 4'h5},
        '{10'h024, 1'b0, 32'h80001, 32'h80003, 32'h2, 4'h9},
        '{10'h104, 1'b0, 32'hff, 32'h123456ff, 32'h12345600, 4'ha},
        '{10'h130, 1'b0, 32'h0, 32'hfff00000, 32'h000fffff, 4'h4}
    };

    xalu_top xalu_top_inst (
        .clk_sys(clk_sys),
        .rst    (rst),
        .apbReq (req),
        .apbRsp (rsp),
        .srOut  (srOut)
    );

    // Free-running 100 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // One transfer; an idle cycle after it keeps drives apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (rsp.pready !== 1'b1 && ++n < 16);
        if (n >= 16)
            errors++;
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        @(posedge clk_sys);
    endtask

    // Mapped reads must also come back without an error answer
    task automatic rd(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        chk(q, want);
        chk({31'h0, e}, 32'h0);
    endtask

    // Watchdog far beyond the expected 460 or so cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        final_report();
    end

    initial
    begin
        errors = 0;
        tests_run = 0;
        rst = 1'b1;
        req = '0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        foreach (rows[i])
        begin
            r = rows[i];
            apb(1'b1, 8'h0c, {16'h0, 16'h00f8 | {15'h0, r.cin}});
            apb(1'b1, 8'h04, r.src);
            apb(1'b1, 8'h08, r.dst);
            apb(1'b1, 8'h00, {22'h0, r.ctl});
            rd(8'h08, r.exp);
            rd(8'h04, r.src);
            rd(8'h0c, {23'h0, r.f[3], 5'h1f, r.f[2:0]});
            chk({16'h0, srOut}, {23'h0, r.f[3], 5'h1f, r.f[2:0]});
            rd(8'h10, r.exp);
            rd(8'h18, {31'h0, r.ctl[2:0] != 3'h3});
        end
        // Pointer steps by unit size; only subtract and XOR advance it
        apb(1'b1, 8'h14, 32'h00100);
        apb(1'b1, 8'h00, 32'h214);
        rd(8'h14, 32'h00102);
        apb(1'b1, 8'h00, 32'h204);
        rd(8'h14, 32'h00103);
        apb(1'b1, 8'h00, 32'h224);
        rd(8'h14, 32'h00107);
        // Unmapped and unaligned places must answer with an error
        apb(1'b1, 8'h1c, 32'h1);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        // Illegal op code only flags itself; operands and status kept
        apb(1'b1, 8'h00, 32'h5);
        rd(8'h18, 32'h2);
        rd(8'h08, 32'h000000ff);
        rd(8'h0c, 32'h000000f9);
        // Second reset mid-run clears the status copy
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(8'h0c, 32'h0);
        chk({16'h0, srOut}, 32'h0);
        final_report();
    end
endmodule
